//--- logic/dbg_sec_pkg.sv
`default_nettype none
package dbg_sec_pkg;
  // ---------------------------------------------------------------
  // Key storage
  // ---------------------------------------------------------------
  localparam int KEY_W = 128;
  localparam int OTP_WORDS = 4;
  localparam logic [31:0] OTP_KEY_ADDR = 32'hf000_0000;
  localparam logic [31:0] OTP_WORD_STEP = 32'h0000_0004;
  // Delivered key, tie-offs and the compare constant (arbitrary values)
  localparam logic [127:0] DELIVERED_KEY = {4{32'hffff_ffff}};
  localparam logic [127:0] HIDDEN_TIE = 128'h5a3c_96e1_0f87_c3d2_69a5_1e78_b4d2_3c0f;
  // Delivered key with an all-zero scan key must match
  localparam logic [127:0] HIDDEN_MATCH = DELIVERED_KEY ^ HIDDEN_TIE;

  // ---------------------------------------------------------------
  // Security tap instructions
  // ---------------------------------------------------------------
  localparam logic [3:0] IR_BOUNDARY = 4'h0;
  localparam logic [3:0] IR_DEBUG = 4'h8;
  localparam logic [3:0] IR_SCAN_KEY = 4'hb;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ---------------------------------------------------------------
  // Debug component table
  // ---------------------------------------------------------------
  localparam logic [9:0] ROM_IDX_CPU = 10'h000;
  localparam logic [9:0] ROM_IDX_RSV1 = 10'h001;
  localparam logic [9:0] ROM_IDX_RSV2 = 10'h002;
  localparam logic [9:0] ROM_IDX_RSV3 = 10'h003;
  localparam logic [9:0] ROM_IDX_END = 10'h004;
  localparam logic [31:0] ROM_VAL_CPU = 32'h0000_1003;
  localparam logic [31:0] ROM_VAL_RSV1 = 32'h0000_2002;
  localparam logic [31:0] ROM_VAL_RSV2 = 32'h0000_3002;
  localparam logic [31:0] ROM_VAL_RSV3 = 32'h0000_4003;
  localparam logic [31:0] ROM_VAL_END = 32'h0000_0000;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_e;
endpackage : dbg_sec_pkg
`default_nettype wire

//--- logic/debug_security_module.sv
// Behaviour
// - Grant access only when key XOR scan key XOR tie-offs equals hidden constant.
// - Visible 128-bit key is fetched from OTP at 0xF0000000; delivered key unlocks.
// - Key bits may only fall from one to zero; clearing any bit locks.
// - An all-zero visible key never grants, whatever is scanned.
// - Instruction 0b1011 puts the scan key register between TDI and TDO.
// - Scan key register cleared only by power-on reset, kept through others.
// - While locked only the security chain is reachable; other chains blocked.
// - Boundary scan shifts through every cell from TDI to TDO.
// - Read-only component table: 0x000 is 0x1003, 0x004 is 0x0 end.
`timescale 1ns/10ps
`default_nettype none
module debug_security_module #(
  parameter int BSC_CELLS = 8
) (
  // System clock domain
  input wire logic clk,
  input wire logic rst,
  // Test clock domain
  input wire logic tck,
  input wire logic power_on_reset_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_en,
  // Visible key storage read port
  output logic otp_rd,
  output logic [31:0] otp_addr,
  input wire logic otp_ack,
  input wire logic [31:0] otp_rdata,
  // Key programming, bits can only be cleared
  input wire logic key_prog_valid,
  input wire logic [1:0] key_prog_index,
  input wire logic [31:0] key_prog_data,
  // Access result
  output logic access_granted,
  // Component table
  input wire logic rom_rd,
  input wire logic [9:0] rom_addr,
  output logic rom_valid,
  output logic [31:0] rom_rdata,
  // Processor debug chain
  output logic dbg_sel,
  input wire logic dbg_tdo,
  // Boundary cells
  input wire logic [BSC_CELLS-1:0] pad_in,
  output logic [BSC_CELLS-1:0] bsc_out,
  output logic bsc_extest
);
  // ---------------------------------------------------------------
  // Checks and helpers
  // ---------------------------------------------------------------
  if (BSC_CELLS < 1) begin : g_bad_cells
    $error("BSC_CELLS must be at least 1");
  end
  // Key words and key width must agree or the fetch leaves holes
  if (dbg_sec_pkg::KEY_W != 32 * dbg_sec_pkg::OTP_WORDS) begin : g_bad_key
    $error("KEY_W must be 32 bits per storage word");
  end

  // Tap state for the next test clock edge
  function automatic dbg_sec_pkg::tap_state_e tap_next(
    input dbg_sec_pkg::tap_state_e s, input logic m);
    case (s)
      dbg_sec_pkg::TAP_RESET: tap_next = m ? dbg_sec_pkg::TAP_RESET : dbg_sec_pkg::TAP_IDLE;
      dbg_sec_pkg::TAP_IDLE: tap_next = m ? dbg_sec_pkg::TAP_SEL_DR : dbg_sec_pkg::TAP_IDLE;
      dbg_sec_pkg::TAP_SEL_DR: tap_next = m ? dbg_sec_pkg::TAP_SEL_IR : dbg_sec_pkg::TAP_CAP_DR;
      dbg_sec_pkg::TAP_CAP_DR,
      dbg_sec_pkg::TAP_SHIFT_DR:
        tap_next = m ? dbg_sec_pkg::TAP_EXIT1_DR : dbg_sec_pkg::TAP_SHIFT_DR;
      dbg_sec_pkg::TAP_EXIT1_DR: tap_next = m ? dbg_sec_pkg::TAP_UPD_DR : dbg_sec_pkg::TAP_PAUSE_DR;
      dbg_sec_pkg::TAP_PAUSE_DR: tap_next = m ? dbg_sec_pkg::TAP_EXIT2_DR : dbg_sec_pkg::TAP_PAUSE_DR;
      dbg_sec_pkg::TAP_EXIT2_DR: tap_next = m ? dbg_sec_pkg::TAP_UPD_DR : dbg_sec_pkg::TAP_SHIFT_DR;
      dbg_sec_pkg::TAP_UPD_DR,
      dbg_sec_pkg::TAP_UPD_IR:
        tap_next = m ? dbg_sec_pkg::TAP_SEL_DR : dbg_sec_pkg::TAP_IDLE;
      dbg_sec_pkg::TAP_SEL_IR: tap_next = m ? dbg_sec_pkg::TAP_RESET : dbg_sec_pkg::TAP_CAP_IR;
      dbg_sec_pkg::TAP_CAP_IR,
      dbg_sec_pkg::TAP_SHIFT_IR:
        tap_next = m ? dbg_sec_pkg::TAP_EXIT1_IR : dbg_sec_pkg::TAP_SHIFT_IR;
      dbg_sec_pkg::TAP_EXIT1_IR: tap_next = m ? dbg_sec_pkg::TAP_UPD_IR : dbg_sec_pkg::TAP_PAUSE_IR;
      dbg_sec_pkg::TAP_PAUSE_IR: tap_next = m ? dbg_sec_pkg::TAP_EXIT2_IR : dbg_sec_pkg::TAP_PAUSE_IR;
      dbg_sec_pkg::TAP_EXIT2_IR: tap_next = m ? dbg_sec_pkg::TAP_UPD_IR : dbg_sec_pkg::TAP_SHIFT_IR;
      default: tap_next = dbg_sec_pkg::TAP_RESET;
    endcase
  endfunction : tap_next

  // Unlisted indices read as zero, like an empty slot
  function automatic logic [31:0] rom_lookup(input logic [9:0] a);
    case (a)
      dbg_sec_pkg::ROM_IDX_CPU: rom_lookup = dbg_sec_pkg::ROM_VAL_CPU;
      dbg_sec_pkg::ROM_IDX_RSV1: rom_lookup = dbg_sec_pkg::ROM_VAL_RSV1;
      dbg_sec_pkg::ROM_IDX_RSV2: rom_lookup = dbg_sec_pkg::ROM_VAL_RSV2;
      dbg_sec_pkg::ROM_IDX_RSV3: rom_lookup = dbg_sec_pkg::ROM_VAL_RSV3;
      dbg_sec_pkg::ROM_IDX_END: rom_lookup = dbg_sec_pkg::ROM_VAL_END;
      default: rom_lookup = 32'h0000_0000;
    endcase
  endfunction : rom_lookup

  // ---------------------------------------------------------------
  // State of both domains
  // ---------------------------------------------------------------
  // Test clock state, cleared by power-on reset only
  typedef struct packed {
    dbg_sec_pkg::tap_state_e tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [127:0] key_sh;
    logic [127:0] scan_key;
    logic key_tog;
    logic bypass;
    logic [BSC_CELLS-1:0] bsc_sh;
    logic [BSC_CELLS-1:0] bsc_upd;
    logic [BSC_CELLS-1:0] pad_s1;
    logic [BSC_CELLS-1:0] pad_s2;
    logic grant_s1;
    logic grant_s2;
    logic tdo;
    logic tdo_en;
    logic dbg_sel;
    logic extest;
  } tck_s;

  // System clock state, cleared by the system reset
  typedef struct packed {
    logic [3:0][31:0] key;
    logic [1:0] idx;
    logic loaded;
    logic rd;
    logic [31:0] addr;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic recap;
    logic [127:0] scan_copy;
    logic granted;
    logic rom_valid;
    logic [31:0] rom_data;
  } sys_s;

  tck_s t_reg;
  tck_s t_next;
  sys_s s_reg;
  sys_s s_next;

  // ---------------------------------------------------------------
  // Test clock side: tap, instruction and data registers
  // ---------------------------------------------------------------
  // Locked taps fall back to bypass so no blocked chain ever shifts
  always_comb begin
    logic locked;
    logic [3:0] ins;
    locked = 1'b0;
    ins = 4'h0;
    t_next = t_reg;
    t_next.tap = tap_next(t_reg.tap, tms);
    t_next.pad_s1 = pad_in;
    t_next.pad_s2 = t_reg.pad_s1;
    t_next.grant_s1 = s_reg.granted;
    t_next.grant_s2 = t_reg.grant_s1;
    locked = !t_reg.grant_s2;
    ins = t_reg.ir;
    if (locked && ins != dbg_sec_pkg::IR_SCAN_KEY) begin
      ins = dbg_sec_pkg::IR_BYPASS;
    end
    t_next.dbg_sel = (ins == dbg_sec_pkg::IR_DEBUG);
    t_next.extest = (ins == dbg_sec_pkg::IR_BOUNDARY);
    case (t_reg.tap)
      dbg_sec_pkg::TAP_RESET: begin
        t_next.ir = dbg_sec_pkg::IR_BYPASS; // Scan key deliberately untouched
      end
      dbg_sec_pkg::TAP_CAP_IR: t_next.ir_sh = dbg_sec_pkg::IR_CAPTURE;
      dbg_sec_pkg::TAP_SHIFT_IR: t_next.ir_sh = {tdi, t_reg.ir_sh[3:1]};
      dbg_sec_pkg::TAP_UPD_IR: t_next.ir = t_reg.ir_sh;
      dbg_sec_pkg::TAP_CAP_DR: begin
        t_next.bypass = 1'b0;
        if (ins == dbg_sec_pkg::IR_SCAN_KEY) begin
          t_next.key_sh = t_reg.scan_key;
        end
        if (ins == dbg_sec_pkg::IR_BOUNDARY) begin
          t_next.bsc_sh = t_reg.pad_s2;
        end
      end
      dbg_sec_pkg::TAP_SHIFT_DR: begin
        case (ins)
          dbg_sec_pkg::IR_SCAN_KEY: t_next.key_sh = {tdi, t_reg.key_sh[127:1]};
          dbg_sec_pkg::IR_BOUNDARY: begin
            t_next.bsc_sh = {tdi, t_reg.bsc_sh[BSC_CELLS-1:1]};
          end
          dbg_sec_pkg::IR_DEBUG: t_next.bypass = 1'b0;
          default: t_next.bypass = tdi;
        endcase
      end
      dbg_sec_pkg::TAP_UPD_DR: begin
        if (ins == dbg_sec_pkg::IR_SCAN_KEY) begin
          t_next.scan_key = t_reg.key_sh;
          t_next.key_tog = !t_reg.key_tog;
        end
        if (ins == dbg_sec_pkg::IR_BOUNDARY) begin
          t_next.bsc_upd = t_reg.bsc_sh;
        end
      end
      default: t_next.bypass = t_reg.bypass;
    endcase
    // Output the bit that will be on the chain end after this edge
    t_next.tdo_en = (t_next.tap == dbg_sec_pkg::TAP_SHIFT_DR)
                 || (t_next.tap == dbg_sec_pkg::TAP_SHIFT_IR);
    if (t_next.tap == dbg_sec_pkg::TAP_SHIFT_IR) begin
      t_next.tdo = t_next.ir_sh[0];
    end else if (t_next.tap == dbg_sec_pkg::TAP_SHIFT_DR) begin
      case (ins)
        dbg_sec_pkg::IR_SCAN_KEY: t_next.tdo = t_next.key_sh[0];
        dbg_sec_pkg::IR_BOUNDARY: t_next.tdo = t_next.bsc_sh[0];
        dbg_sec_pkg::IR_DEBUG: t_next.tdo = dbg_tdo;
        default: t_next.tdo = t_next.bypass;
      endcase
    end else begin
      t_next.tdo = 1'b0;
    end
  end

  // Only power-on reset clears this domain, scan key included
  always_ff @(posedge tck or negedge power_on_reset_n) begin
    if (!power_on_reset_n) begin
      t_reg <= '0;
      t_reg.tap <= dbg_sec_pkg::TAP_RESET;
      t_reg.ir <= dbg_sec_pkg::IR_BYPASS;
    end else begin
      t_reg <= t_next;
    end
  end

  // ---------------------------------------------------------------
  // System side: key fetch, key compare, component table
  // ---------------------------------------------------------------
  // Scan key is quasi-static once its toggle is seen; an update takes
  // several test clocks, far longer than the three-flop toggle path
  always_comb begin
    logic [127:0] vis;
    vis = '0;
    s_next = s_reg;
    s_next.tog_s1 = t_reg.key_tog;
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_s3 = s_reg.tog_s2;
    s_next.rom_valid = rom_rd;
    if (rom_rd) begin
      s_next.rom_data = rom_lookup(rom_addr);
    end
    // Copy again after each toggle edge or after a system reset
    if (s_reg.recap || (s_reg.tog_s2 != s_reg.tog_s3)) begin
      s_next.scan_copy = t_reg.scan_key;
      s_next.recap = 1'b0;
    end
    // Fetch the four key words after every system reset
    if (!s_reg.loaded) begin
      if (!s_reg.rd) begin
        s_next.rd = 1'b1;
        s_next.addr = dbg_sec_pkg::OTP_KEY_ADDR
                    + dbg_sec_pkg::OTP_WORD_STEP * {30'h0, s_reg.idx};
      end else if (otp_ack) begin
        s_next.rd = 1'b0;
        s_next.key[s_reg.idx] = otp_rdata;
        s_next.idx = s_reg.idx + 2'h1;
        s_next.loaded = (s_reg.idx == 2'(dbg_sec_pkg::OTP_WORDS - 1));
      end
    end else if (key_prog_valid) begin
      s_next.key[key_prog_index] = s_reg.key[key_prog_index] & key_prog_data;
    end
    vis = s_reg.key;
    s_next.granted = s_reg.loaded && (vis != '0)
      && ((vis ^ s_reg.scan_copy ^ dbg_sec_pkg::HIDDEN_TIE)
          == dbg_sec_pkg::HIDDEN_MATCH);
  end

  // System reset never touches the scan key; it is copied again after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.recap <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Each output is a state field, so none has a logic path
  assign tdo = t_reg.tdo;
  assign tdo_en = t_reg.tdo_en;
  assign dbg_sel = t_reg.dbg_sel;
  assign bsc_out = t_reg.bsc_upd;
  assign bsc_extest = t_reg.extest;
  assign otp_rd = s_reg.rd;
  assign otp_addr = s_reg.addr;
  assign access_granted = s_reg.granted;
  assign rom_valid = s_reg.rom_valid;
  assign rom_rdata = s_reg.rom_data;
endmodule : debug_security_module
`default_nettype wire

//--- bench/debug_security_properties.sv
`timescale 1ns/10ps
`default_nettype none
module debug_security_properties (
  // Clocks and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic power_on_reset_n,
  // Watched ports
  input wire logic tms,
  input wire logic tdo_en,
  input wire logic otp_rd,
  input wire logic [31:0] otp_addr,
  input wire logic otp_ack,
  input wire logic access_granted,
  input wire logic rom_rd,
  input wire logic [9:0] rom_addr,
  input wire logic rom_valid,
  input wire logic [31:0] rom_rdata,
  input wire logic dbg_sel,
  input wire logic bsc_extest
);
  // ------------------------------------------------------------
  // System clock side
  // ------------------------------------------------------------
  rom_answer_a: assert property (@(posedge clk) disable iff (rst)
    rom_rd |=> rom_valid) else $error("table read not answered");
  rom_first_a: assert property (@(posedge clk) disable iff (rst)
    rom_rd && rom_addr == 10'h000 |=> rom_rdata == 32'h0000_1003) else $error("entry 0 wrong");
  rom_end_a: assert property (@(posedge clk) disable iff (rst)
    rom_rd && rom_addr == 10'h004 |=> rom_rdata == 32'h0000_0000) else $error("end entry wrong");
  otp_window_a: assert property (@(posedge clk) disable iff (rst)
    otp_rd |-> otp_addr[31:4] == 28'hf00_0000 && otp_addr[1:0] == 2'h0) else $error("key address");
  otp_hold_a: assert property (@(posedge clk) disable iff (rst)
    otp_rd && !otp_ack |=> otp_rd && $stable(otp_addr)) else $error("key request dropped");
  otp_gap_a: assert property (@(posedge clk) disable iff (rst)
    otp_ack |=> !otp_rd) else $error("no gap after key word");
  grant_after_load_a: assert property (@(posedge clk) disable iff (rst)
    $rose(access_granted) |-> !otp_rd && !$past(otp_rd)) else $error("grant before key load");
  // ------------------------------------------------------------
  // Test clock side
  // ------------------------------------------------------------
  // Six edges give the grant time to cross over
  locked_chains_a: assert property (@(posedge tck) disable iff (!power_on_reset_n)
    !access_granted [*6] |-> !dbg_sel && !bsc_extest) else $error("chain open while locked");
  tap_quiet_a: assert property (@(posedge tck) disable iff (!power_on_reset_n)
    tms [*5] |=> !tdo_en) else $error("output driven in reset state");
  cover property (@(posedge clk) $rose(access_granted));
  cover property (@(posedge clk) $fell(access_granted));
  cover property (@(posedge tck) bsc_extest);
  cover property (@(posedge tck) dbg_sel);
endmodule : debug_security_properties
`default_nettype wire

//--- bench/jtag_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module jtag_host_model (
  // Test port lines
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // Clock stands low between frames; data idles high between shifts
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One cycle: change after the fall, sample before the rise
  task automatic pulse(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #6;
    q = tdo;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask : pulse
  task automatic idle(input int n);
    logic q;
    repeat (n) pulse(1'b0, 1'b1, q);
  endtask : idle
  task automatic tlr();
    logic q;
    repeat (5) pulse(1'b1, 1'b1, q);
    pulse(1'b0, 1'b1, q);
  endtask : tlr
  // Idle to shift, n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    pulse(1'b1, 1'b1, q);
    if (ir) pulse(1'b1, 1'b1, q);
    pulse(1'b0, 1'b1, q);
    pulse(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, 1'b1, q);
    pulse(1'b0, 1'b1, q);
  endtask : scan
endmodule : jtag_host_model
`default_nettype wire

//--- bench/test_jtag_debug_access_security.sv
`timescale 1ns/10ps
`default_nettype none
module test_jtag_debug_access_security;
  localparam int CELLS = 8;
  logic clk, rst, power_on_reset_n, tck, tms, tdi, tdo, tdo_en, otp_rd, otp_ack;
  logic [31:0] otp_addr, otp_rdata, key_prog_data, rom_rdata;
  logic key_prog_valid, access_granted, rom_rd, rom_valid, dbg_sel, dbg_tdo, bsc_extest;
  logic [1:0] key_prog_index, wcnt;
  logic [9:0] rom_addr;
  logic [CELLS-1:0] pad_in, bsc_out;
  logic [127:0] key_m, scan_m, dout, v;
  logic [31:0] rom_q[$];
  logic [15:0] lf;
  int n_fail, n_checks;
  debug_security_module #(.BSC_CELLS(CELLS)) uut (.clk, .rst, .tck, .power_on_reset_n, .tms,
    .tdi, .tdo, .tdo_en, .otp_rd, .otp_addr, .otp_ack, .otp_rdata, .key_prog_valid,
    .key_prog_index, .key_prog_data, .access_granted, .rom_rd, .rom_addr, .rom_valid,
    .rom_rdata, .dbg_sel, .dbg_tdo, .pad_in, .bsc_out, .bsc_extest);
  jtag_host_model jtag (.tck, .tms, .tdi, .tdo);
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // Bounded wait on the grant level; running out ends the run
  task automatic expect_grant(input logic e);
    int i;
    for (i = 0; i < 400 && access_granted !== e; i++) @(posedge clk);
    chk(access_granted, e);
    if (i == 400) results();
  endtask : expect_grant
  task automatic prog(input logic [1:0] w, input logic [31:0] d);
    @(posedge clk);
    key_prog_valid <= 1'b1;
    key_prog_index <= w;
    key_prog_data <= d;
    key_m[w*32 +: 32] = key_m[w*32 +: 32] & d;
    @(posedge clk);
    key_prog_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : prog
  task automatic ir_dr(input logic [3:0] ir, input int n, input logic [127:0] d);
    jtag.scan(1'b1, 4, {124'h0, ir}, dout);
    chk(dout[3:0], 4'h1);
    jtag.scan(1'b0, n, d, dout);
  endtask : ir_dr
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Key storage answers each request one cycle later, checking its address
  always @(posedge clk) begin
    otp_ack <= !rst && otp_rd && !otp_ack;
    otp_rdata <= key_m[otp_addr[3:2]*32 +: 32];
    wcnt <= rst ? 2'h0 : wcnt + {1'b0, otp_rd && !otp_ack};
    if (otp_rd && !otp_ack) chk(otp_addr, dbg_sec_pkg::OTP_KEY_ADDR + {wcnt, 2'b00});
  end
  // Table answers are matched against the oldest note
  always @(posedge clk) begin
    if (rom_valid === 1'b1) begin
      chk(rom_rdata, rom_q.size() ? rom_q.pop_front() : 32'hdead_beef);
    end
  end
  initial begin
    {rst, key_prog_valid, rom_rd, dbg_tdo, power_on_reset_n} = 5'h13;
    {key_prog_index, key_prog_data, rom_addr, pad_in, n_fail, n_checks} = '0;
    key_m = dbg_sec_pkg::DELIVERED_KEY;
    scan_m = '0;
    lf = 16'h003d;
    @(posedge clk);
    // Tap clock stands still, so only a real falling edge clears the tap
    power_on_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    power_on_reset_n <= 1'b1;
    jtag.tlr();
    expect_grant(1'b1);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      rom_rd <= 1'b1;
      rom_addr <= 10'(k);
      rom_q.push_back(k == 0 ? 32'h1003 : k < 4 ? 32'h1002 + 32'(k) * 32'h1000 + 32'(k / 3) : 0);
    end
    @(posedge clk);
    rom_rd <= 1'b0;
    $display("done: table and fetch");
    prog(2'h0, 32'hffff_fffe);
    expect_grant(1'b0);
    prog(2'h0, 32'hffff_ffff);
    chk(access_granted, 1'b0);
    ir_dr(4'h8, 2, 128'h3);
    chk(dout[1:0], 2'h2);
    chk(dbg_sel, 1'b0);
    ir_dr(4'h0, CELLS, 128'hff);
    chk(bsc_out, 128'h0);
    chk(bsc_extest, 1'b0);
    v = key_m ^ dbg_sec_pkg::DELIVERED_KEY;
    ir_dr(4'hb, 128, v);
    chk(dout, scan_m);
    scan_m = v;
    jtag.idle(6);
    expect_grant(1'b1);
    $display("done: lock and unlock");
    lf = lfsr_next(lf);
    @(posedge clk);
    pad_in <= lf[CELLS-1:0];
    jtag.idle(4);
    lf = lfsr_next(lf);
    ir_dr(4'h0, CELLS, {112'h0, lf});
    chk(dout[CELLS-1:0], pad_in);
    chk(bsc_out, lf[CELLS-1:0]);
    chk(bsc_extest, 1'b1);
    ir_dr(4'h8, 2, 128'h0);
    chk(dout[1:0], 2'h3);
    chk(dbg_sel, 1'b1);
    ir_dr(4'hf, 1, 0);
    $display("done: boundary");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    jtag.idle(4);
    expect_grant(1'b1);
    power_on_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    power_on_reset_n <= 1'b1;
    jtag.tlr();
    expect_grant(1'b0);
    ir_dr(4'hb, 128, v);
    chk(dout, 128'h0);
    $display("done: resets");
    for (int k = 0; k < 4; k++) prog(2'(k), 32'h0);
    ir_dr(4'hb, 128, dbg_sec_pkg::DELIVERED_KEY);
    chk(dout, v);
    jtag.idle(6);
    repeat (20) @(posedge clk);
    chk(access_granted, 1'b0);
    $display("done: zero key");
    results();
  end
endmodule : test_jtag_debug_access_security
bind debug_security_module debug_security_properties props (.clk, .rst, .tck,
  .power_on_reset_n, .tms, .tdo_en, .otp_rd, .otp_addr, .otp_ack, .access_granted, .rom_rd,
  .rom_addr, .rom_valid, .rom_rdata, .dbg_sel, .bsc_extest);
`default_nettype wire
